//--- src/dwbr_map.svh
// Purpose: Constants for the write buffer retire block
// Assumes: Timing counts are in column packet slots
// Notes: Definitions only
`ifndef DWBR_MAP_SVH
`define DWBR_MAP_SVH
`define DWBR_RETIRE_DELAY 4'h2
`define DWBR_WRITE_DATA_DELAY 4'h1
`define DWBR_PRECHARGE_OFFSET 4'h1
`define DWBR_FIFO_DEPTH 32
`define DWBR_BANK_W 5
`define DWBR_COL_W 6
`define DWBR_DEV_W 5
`define DWBR_DATA_W 128
`define DWBR_MASK_W 16
`endif

//--- src/dwbr_pkg.sv
// Purpose: Types for the write buffer retire block
// Assumes: Header map holds all numbers
// Notes: None
`include "dwbr_map.svh"
package dwbr_pkg;
    typedef enum logic [1:0] {
        DWBR_CMD_NOOP = 2'b00,
        DWBR_CMD_WRITE = 2'b01,
        DWBR_CMD_READ = 2'b10
    } dwbr_cmd_e;
    typedef enum logic [1:0] {
        DWBR_ST_EMPTY = 2'b00,
        DWBR_ST_WAIT_DATA = 2'b01,
        DWBR_ST_PENDING = 2'b10
    } dwbr_state_e;
endpackage

//--- src/dwbr_fifo.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes: Full and empty are exact
`timescale 1ns/1ps
`default_nettype none
module dwbr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

//--- src/dwbr_core.sv
// Purpose: Device-side write buffer with delayed automatic retire
// Assumes: One column packet slot per clk; data sampled by an earlier stage
// Notes: Retired words leave through a FIFO to the sense-amp port
//
// How it works
// - Data captured one write-data delay later.
// - Mask applied on retire, else all bytes.
// - Writes load buffer, later retire to sense amp.
// - Retire at framed non-self-read one retire delay.
// - Skipped retire waits for first non-self-read.
// - Reads before retire see old, after see new.
// - Self reads postpone retire without limit.
// - Buffer keeps bank and column, not row.
// - Other-device write retires older buffer.
// - Packet timing measured from packet end.
// - Autoprecharge fires offset plus one slot after retiring packet.
`timescale 1ns/1ps
`default_nettype none
module dwbr_core
    import dwbr_pkg::*;
#(
    parameter logic [`DWBR_DEV_W-1:0] DEV_ID = '0,
    parameter int FIFO_DEPTH = `DWBR_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic col_frame,
    input wire logic [1:0] col_cmd,
    input wire logic col_autopre,
    input wire logic [`DWBR_DEV_W-1:0] col_dev,
    input wire logic [`DWBR_BANK_W-1:0] col_bank,
    input wire logic [`DWBR_COL_W-1:0] col_addr,
    input wire logic byte_mask_valid,
    input wire logic [`DWBR_MASK_W-1:0] byte_mask,
    input wire logic data_valid,
    input wire logic [`DWBR_DATA_W-1:0] data_in,
    output logic sa_valid,
    input wire logic sa_ready,
    output logic [`DWBR_BANK_W-1:0] sa_bank,
    output logic [`DWBR_COL_W-1:0] sa_col,
    output logic [`DWBR_MASK_W-1:0] sa_mask,
    output logic [`DWBR_DATA_W-1:0] sa_data,
    output logic sa_autopre,
    output logic precharge_req,
    output logic [`DWBR_BANK_W-1:0] precharge_bank,
    output logic buf_pending,
    output logic stall
);
    localparam int EW = `DWBR_BANK_W + `DWBR_COL_W + `DWBR_MASK_W + `DWBR_DATA_W + 1;

    dwbr_state_e st_q;
    logic [3:0] age_q;
    logic [3:0] data_cnt_q;
    logic [`DWBR_BANK_W-1:0] bank_q;
    logic [`DWBR_COL_W-1:0] col_q;
    logic [`DWBR_DATA_W-1:0] data_q;
    logic autopre_q;
    logic [3:0] pre_cnt_q;
    logic [`DWBR_BANK_W-1:0] pre_bank_q;
    logic fifo_ready;
    logic retire;
    logic self_read;
    logic self_write;
    logic other_write;
    logic [EW-1:0] entry;

    function automatic logic is_cmd(input logic fr, input logic [1:0] c, input dwbr_cmd_e k);
        return fr && (c == k);
    endfunction

    // A packet counts in the slot whose closing edge samples it
    assign self_read = is_cmd(col_frame, col_cmd, DWBR_CMD_READ) && (col_dev == DEV_ID);
    assign self_write = is_cmd(col_frame, col_cmd, DWBR_CMD_WRITE) && (col_dev == DEV_ID);
    assign other_write = is_cmd(col_frame, col_cmd, DWBR_CMD_WRITE) && (col_dev != DEV_ID);

    // Retire once old enough on a framed packet that is not a read to us
    assign retire = (st_q == DWBR_ST_PENDING) && (age_q >= `DWBR_RETIRE_DELAY)
                    && col_frame && !self_read && fifo_ready;
    // Downstream back-pressure holds the column stream
    assign stall = (st_q == DWBR_ST_PENDING) && !fifo_ready;
    assign buf_pending = (st_q != DWBR_ST_EMPTY);

    // Bank and column only; row is whatever is open at retire time
    assign entry = {bank_q, col_q, (byte_mask_valid ? byte_mask : {`DWBR_MASK_W{1'b1}}),
                    data_q, autopre_q};

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= DWBR_ST_EMPTY;
            age_q <= '0;
            data_cnt_q <= '0;
        end else if (self_write) begin
            // Load step of the two-step write
            st_q <= DWBR_ST_WAIT_DATA;
            age_q <= 4'h1;
            data_cnt_q <= 4'h1;
        end else begin
            if (age_q != 4'hf) begin
                age_q <= age_q + 4'h1;
            end
            if (st_q == DWBR_ST_WAIT_DATA && data_cnt_q >= `DWBR_WRITE_DATA_DELAY && data_valid) begin
                st_q <= DWBR_ST_PENDING;
            end else if (data_cnt_q != 4'hf) begin
                data_cnt_q <= data_cnt_q + 4'h1;
            end
            if (retire) begin
                st_q <= DWBR_ST_EMPTY;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bank_q <= '0;
            col_q <= '0;
            autopre_q <= 1'b0;
            data_q <= '0;
        end else begin
            if (self_write) begin
                bank_q <= col_bank;
                col_q <= col_addr;
                autopre_q <= col_autopre;
            end
            if (st_q == DWBR_ST_WAIT_DATA && data_valid) begin
                data_q <= data_in;
            end
        end
    end

    // Autoprecharge fires a fixed offset after the retiring packet
    always_ff @(posedge clk) begin
        if (rst) begin
            pre_cnt_q <= '0;
            pre_bank_q <= '0;
            precharge_req <= 1'b0;
        end else begin
            precharge_req <= 1'b0;
            if (retire && autopre_q) begin
                pre_cnt_q <= `DWBR_PRECHARGE_OFFSET;
                pre_bank_q <= bank_q;
            end else if (pre_cnt_q != '0) begin
                pre_cnt_q <= pre_cnt_q - 4'h1;
                precharge_req <= (pre_cnt_q == 4'h1);
            end
        end
    end
    assign precharge_bank = pre_bank_q;

    dwbr_fifo #(
        .WIDTH(EW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_data(entry),
        .in_valid(retire),
        .in_ready(fifo_ready),
        .out_data({sa_bank, sa_col, sa_mask, sa_data, sa_autopre}),
        .out_valid(sa_valid),
        .out_ready(sa_ready)
    );


    // Checks on buffer load, retire ordering and precharge timing
    a_self_read_holds: assert property (@(posedge clk) disable iff (rst)
        self_read |-> !retire)
        else $error("retire on self read");
    a_retire_age: assert property (@(posedge clk) disable iff (rst)
        retire |-> age_q >= 4'h2)
        else $error("retire too early");
    a_retire_frame: assert property (@(posedge clk) disable iff (rst)
        retire |-> col_frame)
        else $error("retire without packet");
    a_retire_empties: assert property (@(posedge clk) disable iff (rst)
        retire && !self_write |=> !buf_pending)
        else $error("buffer not emptied");
    a_write_loads: assert property (@(posedge clk) disable iff (rst)
        self_write |=> buf_pending && bank_q == $past(col_bank))
        else $error("write not loaded");
    a_mask_default: assert property (@(posedge clk) disable iff (rst)
        retire && !byte_mask_valid |-> entry[`DWBR_DATA_W+1 +: `DWBR_MASK_W] == '1)
        else $error("mask not full");
    a_other_retires: assert property (@(posedge clk) disable iff (rst)
        other_write && st_q == DWBR_ST_PENDING && age_q >= 4'h2 && fifo_ready |-> retire)
        else $error("other write kept buffer");
    a_autopre_time: assert property (@(posedge clk) disable iff (rst)
        retire && autopre_q |-> ##1 !precharge_req ##1 precharge_req)
        else $error("precharge timing");
    a_data_capture: assert property (@(posedge clk) disable iff (rst)
        st_q == DWBR_ST_WAIT_DATA && data_valid && !self_write |=> data_q == $past(data_in))
        else $error("write data not captured");
    a_read_postpones: assert property (@(posedge clk) disable iff (rst)
        self_read && st_q == DWBR_ST_PENDING |=> buf_pending)
        else $error("self read dropped buffer");
    a_autopre_bank: assert property (@(posedge clk) disable iff (rst)
        retire && autopre_q |=> precharge_bank == $past(bank_q))
        else $error("precharge bank wrong");

    c_normal_retire: cover property (@(posedge clk) self_write ##2 retire);
    c_held_retire: cover property (@(posedge clk) self_read && st_q == DWBR_ST_PENDING ##1 retire);
    c_autopre: cover property (@(posedge clk) precharge_req);
    c_masked_retire: cover property (@(posedge clk) retire && byte_mask_valid);
    c_stalled: cover property (@(posedge clk) stall);
endmodule
`default_nettype wire

//--- tb/dwbr_ctl_model.sv
// Purpose: Controller model driving column, mask and data slots
// Assumes: One packet slot per clk edge, driven just after the edge
// Notes: Idle mask and data lines in pkt slots show the inverse of their last value; row_gap leaves them as they were
`timescale 1ns/1ps
`default_nettype none
module dwbr_ctl_model (
    input wire logic clk,
    output logic col_frame,
    output logic [1:0] col_cmd,
    output logic col_autopre,
    output logic [4:0] col_dev,
    output logic [4:0] col_bank,
    output logic [5:0] col_addr,
    output logic byte_mask_valid,
    output logic [15:0] byte_mask,
    output logic data_valid,
    output logic [127:0] data_in
);
    initial begin
        col_frame = 1'h0;
        col_cmd = 2'h0;
        col_autopre = 1'h0;
        col_dev = 5'h00;
        col_bank = 5'h00;
        col_addr = 6'h00;
        byte_mask_valid = 1'h0;
        byte_mask = 16'h0000;
        data_valid = 1'h0;
        data_in = 128'h0;
    end
    // Flags: frame, mask, data, autoprecharge; order and spacing come from the caller
    task automatic pkt(input logic [1:0] c, input logic [4:0] d, input logic [5:0] a, input logic [3:0] fl);
        @(posedge clk);
        #1;
        col_frame = fl[3];
        col_cmd = c;
        col_dev = d;
        col_bank = a[4:0];
        col_addr = a;
        col_autopre = fl[0];
        byte_mask_valid = fl[2];
        byte_mask = fl[2] ? 16'h0f0f : ~byte_mask;
        data_valid = fl[1];
        data_in = fl[1] ? {8{10'h2a5, a}} : ~data_in;
    endtask
    // Unframed slots stand for row-side spacing: activate to column, precharge, row cycle
    task automatic row_gap(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            col_frame = 1'h0;
            data_valid = 1'h0;
            byte_mask_valid = 1'h0;
        end
    endtask
endmodule
`default_nettype wire

//--- tb/dram_write_buffer_retire_test.sv
// Purpose: Self-checking bench for the write buffer retire core
// Assumes: Controller model supplies every column, mask and data slot
// Notes: Retired words are collected by a monitor at the handshake
`timescale 1ns/1ps
`default_nettype none
module dram_write_buffer_retire_test
    import dwbr_pkg::*;
;
    logic clk, rst, sa_ready, col_frame, col_autopre, byte_mask_valid, data_valid;
    logic sa_valid, sa_autopre, precharge_req, buf_pending, stall;
    logic [1:0] col_cmd;
    logic [4:0] col_dev, col_bank, sa_bank, precharge_bank, pre_b;
    logic [5:0] col_addr, sa_col;
    logic [15:0] byte_mask, sa_mask;
    logic [127:0] data_in, sa_data;
    logic [43:0] got_q[$];
    int bad_count, comparisons, pre_n;
    dwbr_ctl_model ctl_u (.clk, .col_frame, .col_cmd, .col_autopre, .col_dev, .col_bank, .col_addr,
        .byte_mask_valid, .byte_mask, .data_valid, .data_in);
    dwbr_core dut_u (.clk, .rst, .col_frame, .col_cmd, .col_autopre, .col_dev, .col_bank, .col_addr,
        .byte_mask_valid, .byte_mask, .data_valid, .data_in, .sa_valid, .sa_ready, .sa_bank, .sa_col,
        .sa_mask, .sa_data, .sa_autopre, .precharge_req, .precharge_bank, .buf_pending, .stall);
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (sa_valid === 1'h1 && sa_ready === 1'h1)
            got_q.push_back({sa_autopre, sa_bank, sa_col, sa_mask, sa_data[15:0]});
        if (precharge_req === 1'h1) begin
            pre_n++;
            pre_b = precharge_bank;
        end
    end
    function automatic logic [43:0] ex(input logic ap, input logic [5:0] a, input logic [15:0] m);
        return {ap, a[4:0], a, m, 10'h2a5, a};
    endfunction
    task automatic ck(input logic ok, input string s);
        comparisons++;
        if (!ok) begin
            bad_count++;
            $display("CHECK FAILED %0t %s", $time, s);
        end
    endtask
    // Framed no-ops keep the column stream alive while waiting for a retired word
    task automatic chk(input logic [43:0] e);
        logic [43:0] g;
        g = 'x;
        for (int i = 0; i < 8 && got_q.size() == 0; i++) ctl_u.pkt(DWBR_CMD_NOOP, 5'h00, 6'h00, 4'h8);
        if (got_q.size() != 0) g = got_q.pop_front();
        ck(g === e, "retired word mismatch");
    endtask
    task automatic t_plain();
        ctl_u.pkt(DWBR_CMD_WRITE, 5'h00, 6'h03, 4'h8);
        ctl_u.pkt(DWBR_CMD_NOOP, 5'h00, 6'h03, 4'ha);
        ctl_u.pkt(DWBR_CMD_NOOP, 5'h00, 6'h03, 4'h8);
        chk(ex(1'h0, 6'h03, 16'hffff));
    endtask
    task automatic t_held();
        ctl_u.pkt(DWBR_CMD_WRITE, 5'h00, 6'h05, 4'h8);
        ctl_u.pkt(DWBR_CMD_NOOP, 5'h00, 6'h05, 4'ha);
        ctl_u.pkt(DWBR_CMD_READ, 5'h00, 6'h05, 4'h8);
        ctl_u.pkt(DWBR_CMD_NOOP, 5'h00, 6'h05, 4'h0);
        ctl_u.pkt(DWBR_CMD_READ, 5'h00, 6'h11, 4'h8);
        ctl_u.pkt(DWBR_CMD_WRITE, 5'h01, 6'h05, 4'hc);
        ck(buf_pending === 1'h1 && got_q.size() == 0, "retire not held off");
        chk(ex(1'h0, 6'h05, 16'h0f0f));
    endtask
    task automatic t_autopre();
        int n;
        ctl_u.pkt(DWBR_CMD_WRITE, 5'h00, 6'h09, 4'h9);
        ctl_u.pkt(DWBR_CMD_NOOP, 5'h00, 6'h09, 4'ha);
        ctl_u.pkt(DWBR_CMD_NOOP, 5'h00, 6'h09, 4'h8);
        n = pre_n;
        chk(ex(1'h1, 6'h09, 16'hffff));
        repeat (3) ctl_u.pkt(DWBR_CMD_NOOP, 5'h00, 6'h00, 4'h8);
        ck(pre_n == n + 1 && pre_b === 5'h09, "precharge pulse");
    endtask
    task automatic t_fill();
        sa_ready = 1'h0;
        for (int i = 0; i < 33; i++) begin
            ctl_u.pkt(DWBR_CMD_WRITE, 5'h00, 6'(i), 4'h8);
            ctl_u.pkt(DWBR_CMD_NOOP, 5'h00, 6'(i), 4'ha);
            ctl_u.pkt(DWBR_CMD_NOOP, 5'h00, 6'(i), 4'h8);
        end
        #1;
        ck(stall === 1'h1 && buf_pending === 1'h1, "no stall when full");
        sa_ready = 1'h1;
        for (int i = 0; i < 33; i++) chk(ex(1'h0, 6'(i), 16'hffff));
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #300000;
        bad_count++;
        give_verdict();
    end
    initial begin
        rst = 1'h1;
        sa_ready = 1'h1;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'h0;
        t_plain();
        ctl_u.row_gap(8);
        t_held();
        ctl_u.row_gap(8);
        t_autopre();
        ctl_u.row_gap(8);
        t_fill();
        give_verdict();
    end
endmodule
`default_nettype wire
